// ### arac_pkg.sv
// package: register map, field positions and types for the converter control block
package arac_pkg;
  localparam logic [11:0] OFF_CHANNEL_GO = 12'h000;
  localparam logic [11:0] OFF_FORMAT_CFG = 12'h004;
  localparam logic [11:0] OFF_TRIGGER_CFG = 12'h008;
  localparam logic [11:0] OFF_RESULT_HIGH = 12'h00c;
  localparam logic [11:0] OFF_RESULT_LOW = 12'h010;
  localparam logic [11:0] OFF_IRQ_STATUS = 12'h014;
  localparam logic [11:0] OFF_IRQ_MASK = 12'h018;
  localparam int RESULT_BITS = 10;
  localparam int STEP_COUNT = 1024;
  localparam int BIT_GO = 1;
  localparam int BIT_ENABLE = 0;
  localparam int BIT_JUSTIFY = 7;
  localparam logic [7:0] MASK_CHANNEL_GO = 8'h7f;
  localparam logic [7:0] MASK_FORMAT_CFG = 8'hf7;
  localparam logic [7:0] MASK_TRIGGER_CFG = 8'hf0;
  localparam logic [3:0] TRIG_NONE = 4'h0;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam int CLK_MHZ = 200;
  localparam int CONV_NS = 100;
  localparam int CONV_CYCLES = (CONV_NS * CLK_MHZ + 999) / 1000;
  typedef struct packed {
    logic [7:0] high;
    logic [7:0] low;
  } arac_result_type;
  typedef enum logic [0:0] {
    ARAC_IDLE = 1'b0,
    ARAC_CONVERT = 1'b1
  } arac_state_type;
endpackage

// ### arac_top.sv
// converter control: apb registers, conversion sequencing, result formatting, interrupt
`timescale 1ns/1ps
module arac_top
  import arac_pkg::*;
#(
  parameter int CONV_LEN = CONV_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [15:1] trigger_sources,
  input wire logic [RESULT_BITS-1:0] sample_code,
  output logic sample_hold,
  output logic [4:0] input_channel_select,
  output logic [2:0] conversion_clock_select,
  output logic negative_reference_select,
  output logic [1:0] positive_reference_select,
  output logic irq
);
  logic [7:0] chan_go_reg;
  logic [7:0] fmt_cfg_reg;
  logic [7:0] trig_cfg_reg;
  arac_result_type result_reg;
  logic [0:0] irq_stat_reg;
  logic [0:0] irq_mask_reg;
  arac_state_type state_reg;
  logic [15:0] conv_cnt_reg;
  logic [15:1] trig_s1_reg;
  logic [15:1] trig_s2_reg;
  logic [15:1] trig_s3_reg;
  logic [31:0] prdata_reg;
  logic irq_reg;
  logic pready_reg;
  logic pslverr_reg;

  wire access = psel && penable && !pready_reg;
  wire wr_en = access && pwrite;
  wire wr_chan = wr_en && paddr == OFF_CHANNEL_GO;
  wire wr_fmt = wr_en && paddr == OFF_FORMAT_CFG;
  wire wr_trig = wr_en && paddr == OFF_TRIGGER_CFG;
  wire wr_high = wr_en && paddr == OFF_RESULT_HIGH;
  wire wr_low = wr_en && paddr == OFF_RESULT_LOW;
  wire wr_stat = wr_en && paddr == OFF_IRQ_STATUS;
  wire wr_mask = wr_en && paddr == OFF_IRQ_MASK;
  wire mapped = paddr inside {OFF_CHANNEL_GO, OFF_FORMAT_CFG, OFF_TRIGGER_CFG,
    OFF_RESULT_HIGH, OFF_RESULT_LOW, OFF_IRQ_STATUS, OFF_IRQ_MASK};
  wire enabled = chan_go_reg[BIT_ENABLE];
  wire [3:0] trig_sel = trig_cfg_reg[7:4];
  // synchronised sources; rising edge taken between second and third stage
  wire [15:1] trig_rise = trig_s2_reg & ~trig_s3_reg;
  wire trig_hit = trig_sel != TRIG_NONE && trig_rise[trig_sel];
  wire sw_go = wr_chan && pwdata[BIT_GO];
  wire start = enabled && state_reg == ARAC_IDLE && (sw_go || trig_hit);
  wire done = state_reg == ARAC_CONVERT && conv_cnt_reg == 16'(CONV_LEN - 1);
  wire [RESULT_BITS-1:0] code = sample_code;
  wire justify_right = fmt_cfg_reg[BIT_JUSTIFY];
  arac_result_type fmt_result;
  // typed patterns so each arm of the select has a known layout
  assign fmt_result = justify_right ?
    arac_result_type'{high: {6'h00, code[9:8]}, low: code[7:0]} :
    arac_result_type'{high: code[9:2], low: {code[1:0], 6'h00}};
  wire go_flag = state_reg == ARAC_CONVERT;
  wire [7:0] chan_view = (chan_go_reg & MASK_CHANNEL_GO & ~8'h02) | {6'h00, go_flag, 1'b0};
  wire [7:0] rd_byte = paddr == OFF_CHANNEL_GO ? chan_view :
                       paddr == OFF_FORMAT_CFG ? fmt_cfg_reg :
                       paddr == OFF_TRIGGER_CFG ? trig_cfg_reg :
                       paddr == OFF_RESULT_HIGH ? result_reg.high :
                       paddr == OFF_RESULT_LOW ? result_reg.low :
                       paddr == OFF_IRQ_STATUS ? {7'h00, irq_stat_reg} :
                       paddr == OFF_IRQ_MASK ? {7'h00, irq_mask_reg} : RESET_BYTE;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trig_s1_reg <= '0;
      trig_s2_reg <= '0;
      trig_s3_reg <= '0;
    end else if (clk_en) begin
      trig_s1_reg <= trigger_sources;
      trig_s2_reg <= trig_s1_reg;
      trig_s3_reg <= trig_s2_reg;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chan_go_reg <= RESET_BYTE;
      fmt_cfg_reg <= RESET_BYTE;
      trig_cfg_reg <= RESET_BYTE;
      irq_mask_reg <= 1'b0;
    end else if (clk_en) begin
      if (wr_chan) chan_go_reg <= pwdata[7:0] & MASK_CHANNEL_GO & ~8'h02;
      if (wr_fmt) fmt_cfg_reg <= pwdata[7:0] & MASK_FORMAT_CFG;
      if (wr_trig) trig_cfg_reg <= pwdata[7:0] & MASK_TRIGGER_CFG;
      if (wr_mask) irq_mask_reg <= pwdata[0];
    end
  end

  // clearing enable aborts a running conversion; result keeps its last value
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= ARAC_IDLE;
      conv_cnt_reg <= '0;
    end else if (clk_en) begin
      if (!enabled) state_reg <= ARAC_IDLE;
      else if (start) state_reg <= ARAC_CONVERT;
      else if (done) state_reg <= ARAC_IDLE;
      conv_cnt_reg <= (start || !go_flag) ? 16'h0000 : conv_cnt_reg + 16'h0001;
    end
  end

  // both bytes load in the done cycle, same edge that drops the go flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result_reg <= '0;
    end else if (clk_en) begin
      if (done && enabled) result_reg <= fmt_result;
      else begin
        if (wr_high) result_reg.high <= pwdata[7:0];
        if (wr_low) result_reg.low <= pwdata[7:0];
      end
    end
  end

  // set wins over write-one-to-clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_reg <= 1'b0;
      irq_reg <= 1'b0;
    end else if (clk_en) begin
      if (done && enabled) irq_stat_reg <= 1'b1;
      else if (wr_stat && pwdata[0]) irq_stat_reg <= 1'b0;
      irq_reg <= |(irq_stat_reg & irq_mask_reg);
    end
  end

  // one wait state: answer in the second access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= '0;
    end else if (clk_en) begin
      pready_reg <= access;
      pslverr_reg <= access && !mapped;
      prdata_reg <= access && !pwrite ? {24'h000000, rd_byte} : 32'h00000000;
    end
  end

  // hold capacitor tracks while idle and is never discharged here
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) sample_hold <= 1'b0;
    else if (clk_en) sample_hold <= (start || go_flag) && !done && enabled;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      input_channel_select <= '0;
      conversion_clock_select <= '0;
      negative_reference_select <= 1'b0;
      positive_reference_select <= '0;
    end else if (clk_en) begin
      input_channel_select <= chan_go_reg[6:2];
      conversion_clock_select <= fmt_cfg_reg[6:4];
      negative_reference_select <= fmt_cfg_reg[2];
      positive_reference_select <= fmt_cfg_reg[1:0];
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign irq = irq_reg;

  a_right_high: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && done && enabled && justify_right |=> result_reg.high[7:2] == 6'h00)
    else $error("right justify high byte upper bits not zero");
  a_right_low: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && done && enabled && justify_right |=> result_reg.low == $past(sample_code[7:0]))
    else $error("right justify low byte mismatch");
  a_left_pack: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && done && enabled && !justify_right |=>
      {result_reg.high, result_reg.low[7:6]} == $past(sample_code) && result_reg.low[5:0] == 0)
    else $error("left justify layout wrong");
  sequence s_started;
    clk_en && start;
  endsequence
  a_go_clears: assert property (@(posedge pclk) disable iff (!presetn)
    s_started ##1 (clk_en && go_flag && enabled)[*1] |-> ##[0:1000] !go_flag)
    else $error("go flag did not clear");
  a_go_sets: assert property (@(posedge pclk) disable iff (!presetn)
    s_started |=> go_flag)
    else $error("go flag not set by start");
  a_disable_idle: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && !enabled |=> !go_flag && !sample_hold)
    else $error("converter active while disabled");
  a_trig_none: assert property (@(posedge pclk) disable iff (!presetn)
    trig_sel == TRIG_NONE && !sw_go |-> !start)
    else $error("start with trigger disabled");
  a_done_irq: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && done && enabled |=>
      irq_stat_reg && !go_flag && result_reg == $past(fmt_result))
    else $error("result load and flag out of step");
  a_hold_start: assert property (@(posedge pclk) disable iff (!presetn)
    s_started |=> sample_hold)
    else $error("sampling switch not opened by start");
endmodule

// ### arac_channel_model.sv
// behavioural analog channel and hold capacitor feeding the converter code
`timescale 1ns/1ps
module arac_channel_model
  import arac_pkg::*;
#(
  parameter int ACQ_CYCLES = 924
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic sample_hold,
  input wire logic [4:0] input_channel_select,
  input wire logic [9:0] level,
  output logic [RESULT_BITS-1:0] sample_code
);
  logic [9:0] cap_reg;
  logic [15:0] acq_cnt_reg;
  logic [4:0] chan_prev_reg;
  logic short_reg;
  // tracks only while the switch is closed, never discharged between conversions
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cap_reg <= 10'h2aa;
    end else if (!sample_hold) begin
      cap_reg <= level ^ {5'h00, input_channel_select};
    end
  end
  // a start before a full acquisition after a channel change reads a spoiled code,
  // so an early start shows up as a result mismatch in the bench
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acq_cnt_reg <= '0;
      chan_prev_reg <= '0;
      short_reg <= 1'b0;
    end else begin
      chan_prev_reg <= input_channel_select;
      if (input_channel_select != chan_prev_reg) acq_cnt_reg <= '0;
      else if (!sample_hold && acq_cnt_reg != 16'hffff) acq_cnt_reg <= acq_cnt_reg + 16'h0001;
      if (!sample_hold) short_reg <= acq_cnt_reg < 16'(ACQ_CYCLES);
    end
  end
  assign sample_code = short_reg ? ~cap_reg : cap_reg; // ten-bit code
endmodule

// ### adc_result_and_acquisition_bench.sv
// self-checking bench for the converter control block
`timescale 1ns/1ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin num_errors++; \
  $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module adc_result_and_acquisition_bench;
  import arac_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err;
  logic sample_hold, neg_ref, irq;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic [15:1] trig = '0;
  logic [9:0] code, lvl = '0;
  logic [4:0] chan;
  logic [2:0] cclk;
  logic [1:0] pos_ref;
  logic [15:0] seed = 16'h002a;
  int num_errors = 0, cmp_count = 0;
  // amplifier settling, hold charge, and margin for 25 degrees above room
  localparam int ACQ_CYC = (2000 + 1370 + 25 * 50) * CLK_MHZ / 1000;
  initial forever #2.5 pclk = ~pclk;
  // short conversion keeps the run brief
  arac_top #(.CONV_LEN(4)) uut (.pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .trigger_sources(trig), .sample_code(code),
    .sample_hold(sample_hold), .input_channel_select(chan), .conversion_clock_select(cclk),
    .negative_reference_select(neg_ref), .positive_reference_select(pos_ref), .irq(irq));
  arac_channel_model #(.ACQ_CYCLES(ACQ_CYC)) model (.pclk(pclk), .presetn(presetn),
    .sample_hold(sample_hold),
    .input_channel_select(chan), .level(lvl), .sample_code(code));
  function automatic logic [15:0] nxt(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [15:0] fmt(input logic j, input logic [9:0] c);
    return j ? {6'h00, c[9:8], c[7:0]} : {c[9:2], c[1:0], 6'h00};
  endfunction
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    // pready is read before this edge's own updates land
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0; penable <= 0;
  endtask
  task automatic conv(input logic j, input logic [9:0] v, input logic [4:0] ch);
    logic [7:0] h;
    logic b;
    int n;
    lvl <= v;
    apb(1, OFF_FORMAT_CFG, {24'h0, j, 7'h35});
    apb(1, OFF_CHANNEL_GO, {25'h0, ch, 2'b01});
    repeat (ACQ_CYC) @(posedge pclk); // full acquisition after channel change
    `CHK("cclk", 3'h3, cclk)
    `CHK("chan", ch, chan)
    `CHK("refs", 3'h5, {neg_ref, pos_ref})
    apb(1, OFF_CHANNEL_GO, {25'h0, ch, 2'b11});
    `CHK("hold", 1'b1, sample_hold)
    n = 0;
    b = 1'b0;
    do begin
      apb(0, OFF_CHANNEL_GO, 0);
      n++;
      if (n == 1) b = rd[1];
    end while (rd[1] !== 1'b0 && n < 40);
    `CHK("busy", 1'b1, b)
    `CHK("go", 1'b0, rd[1])
    `CHK("hold off", 1'b0, sample_hold)
    apb(0, OFF_RESULT_HIGH, 0);
    h = rd[7:0];
    apb(0, OFF_RESULT_LOW, 0);
    `CHK("result", fmt(j, v ^ {5'h00, ch}), {h, rd[7:0]})
  endtask
  task automatic wrap_up;
    if (num_errors == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge pclk);
    num_errors++;
    wrap_up();
  end
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1;
    apb(0, OFF_CHANNEL_GO, 0);
    `CHK("reset", 32'h0, rd)
    apb(1, OFF_TRIGGER_CFG, 32'hff);
    apb(0, OFF_TRIGGER_CFG, 0);
    `CHK("trigcfg", {24'h0, MASK_TRIGGER_CFG}, rd)
    apb(0, 12'h01c, 0);
    `CHK("unmapped", 2'b01, {rd[0], err})
    // corners then random codes, both justifications
    conv(1, 10'h3ff, 5'h00);
    conv(0, 10'h3ff, 5'h00);
    conv(1, 10'h155, 5'h1f);
    for (int i = 0; i < 12; i++) begin
      seed = nxt(seed);
      conv(seed[15], seed[9:0], seed[14:10]);
    end
    apb(1, OFF_IRQ_STATUS, 1);
    apb(1, OFF_IRQ_MASK, 1);
    `CHK("irq idle", 1'b0, irq)
    conv(0, 10'h2a5, 5'h03);
    `CHK("irq on", 1'b1, irq)
    apb(1, OFF_IRQ_STATUS, 1);
    apb(0, OFF_IRQ_STATUS, 0);
    `CHK("status", 1'b0, rd[0])
    `CHK("irq off", 1'b0, irq)
    apb(1, OFF_IRQ_MASK, 0);
    conv(1, 10'h0f0, 5'h04);
    `CHK("masked", 1'b0, irq)
    // go with the converter disabled is ignored
    // channel 4 is kept so the trigger runs need no new acquisition
    apb(1, OFF_CHANNEL_GO, 32'h10);
    apb(1, OFF_CHANNEL_GO, 32'h12);
    apb(0, OFF_CHANNEL_GO, 0);
    `CHK("disabled", 1'b0, rd[1])
    apb(1, OFF_CHANNEL_GO, 32'h11);
    foreach (seed[k]) if (k < 2) begin
      apb(1, OFF_IRQ_STATUS, 1);
      apb(1, OFF_TRIGGER_CFG, k ? 32'h50 : 32'h00);
      trig <= 15'h7fff;
      repeat (4) @(posedge pclk);
      trig <= '0;
      repeat (30) @(posedge pclk);
      apb(0, OFF_IRQ_STATUS, 0);
      `CHK("trigger", k[0], rd[0])
    end
    wrap_up();
  end
endmodule
